// File: b4ds_master.sv
// ----
// Bus master model on the far side of the port
// ----
module b4ds_master (
   output logic             linkClk,
   output logic             read_port_select_n,
   output logic             write_port_select_n,
   output logic [3:0]       addr,
   output logic [35:0]      writeBeats,
   output logic [3:0]       lane_write_select_n,
   input  wire logic [35:0] readBeats,
   input  wire logic [1:0]  readBeatOe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic clkRun;

   // input clock source.
   // The clock only stops low, so a pause never leaves a short high pulse behind.
   initial
   begin
      linkClk = 1'b0;
      clkRun = 1'b1;
      read_port_select_n = 1'b1;
      write_port_select_n = 1'b1;
      addr = 4'h0;
      writeBeats = 36'h0;
      lane_write_select_n = 4'hF;
      #3.1;
      forever
      begin
         #7.5;
         if (clkRun || linkClk)
            linkClk = ~linkClk;
      end
   end

   // write burst.
   // With dup set the select stays low one rise more, aimed four words on.
   task automatic write_burst(input logic [3:0] a, input logic [71:0] d,
                              input logic [7:0] sel, input bit dup);
      @(negedge linkClk);
      write_port_select_n = 1'b0;
      addr = a;
      @(negedge linkClk);
      write_port_select_n = !dup;
      addr = a + 4'h4;
      writeBeats = d[35:0];
      lane_write_select_n = sel[3:0];
      @(negedge linkClk);
      write_port_select_n = 1'b1;
      addr = ~addr;
      writeBeats = d[71:36];
      lane_write_select_n = sel[7:4];
      @(negedge linkClk);
      // Released lines show inverted data so stale values never look valid.
      writeBeats = ~writeBeats;
      lane_write_select_n = 4'hF;
   endtask : write_burst

   // read burst, capturing beats and enables after each rise.
   task automatic read_burst(input logic [3:0] a, input bit dup,
                             output logic [71:0] q, output logic [7:0] oe);
      @(negedge linkClk);
      read_port_select_n = 1'b0;
      addr = a;
      @(negedge linkClk);
      read_port_select_n = !dup;
      addr = a + 4'h4;
      @(negedge linkClk);
      read_port_select_n = 1'b1;
      addr = ~addr;
      q[17:0] = readBeats[35:18];
      oe[1:0] = readBeatOe;
      @(negedge linkClk);
      q[53:18] = readBeats;
      oe[3:2] = readBeatOe;
      @(negedge linkClk);
      q[71:54] = readBeats[17:0];
      oe[5:4] = readBeatOe;
      @(negedge linkClk);
      oe[7:6] = readBeatOe;
   endtask : read_burst
endmodule : b4ds_master

// File: b4ds_pkg.sv
package b4ds_pkg;

   // ----------------------------------------------------------------
   // Delay loop timing
   // ----------------------------------------------------------------

   // Link clock cycles of stable clock before the loop reports lock.
   localparam int unsigned LOCK_CYCLES = 1024;

   // System clock rate in MHz.
   localparam int unsigned CLK_SYS_MHZ = 25;

   // Least pause of the link clock that resets the loop, in ns.
   localparam int unsigned STOP_NS = 30;

   // The pause rounded up to whole system cycles, at least one.
   localparam int unsigned STOP_RAW = (STOP_NS * CLK_SYS_MHZ + 999) / 1000;
   localparam int unsigned STOP_CYCLES = (STOP_RAW < 1) ? 1 : STOP_RAW;

   // Extra cycles that cover the heartbeat half period at the slowest clock.
   localparam int unsigned HEART_SLACK = 3;

   // Idle cycles without heartbeat before the link clock counts as stopped.
   localparam logic [3:0] IDLE_LIMIT = 4'(STOP_CYCLES + HEART_SLACK);

   // Width of the link heartbeat counter; its top bit crosses to clk_sys.
   localparam int unsigned HEART_W = 3;

   // ----------------------------------------------------------------
   // Burst and lane layout
   // ----------------------------------------------------------------

   // Offsets of the burst words behind the latched address.
   localparam int unsigned OFS_SECOND = 1;
   localparam int unsigned OFS_THIRD  = 2;
   localparam int unsigned OFS_LAST   = 3;

   // Position of the lane selects of each beat in the select bus.
   localparam int unsigned SEL_TRUE = 0;
   localparam int unsigned SEL_COMP = 2;

   // Reset value of the read output enables: outputs released.
   localparam logic [1:0] OE_RESET = 2'h0;

endpackage : b4ds_pkg

// File: b4ds_port.sv
module b4ds_port #(
   parameter int unsigned ADDR_W   = 4,
   parameter int unsigned DATA_W   = 18,
   parameter int unsigned LOCK_CYC = b4ds_pkg::LOCK_CYCLES
) (
   input  wire logic                clk_sys,
   input  wire logic                reset,
   input  wire logic                linkClk,
   input  wire logic                loop_disable_strap,
   input  wire logic                outClkTrue,
   input  wire logic                outClkComp,
   input  wire logic                read_port_select_n,
   input  wire logic                write_port_select_n,
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [2*DATA_W-1:0] writeBeats,
   input  wire logic [3:0]          lane_write_select_n,
   output logic      [2*DATA_W-1:0] readBeats,
   output logic      [1:0]          readBeatOe,
   output logic                     singleClockMode,
   output logic                     dllBypass,
   output logic                     dllLocked
);
   localparam int unsigned DEPTH  = 2 ** ADDR_W;
   localparam int unsigned LANE   = DATA_W / 2;
   localparam int unsigned LOCK_W = $clog2(LOCK_CYC + 1);
   localparam logic [LOCK_W-1:0] LOCK_END = LOCK_W'(LOCK_CYC);

   // ----------------------------------------------------------------
   // State of both domains
   // ----------------------------------------------------------------

   typedef struct packed {
      logic [DEPTH-1:0][DATA_W-1:0]    mem;
      logic [ADDR_W-1:0]               rdAddr;
      logic [ADDR_W-1:0]               rdTail;
      logic [ADDR_W-1:0]               wrAddr;
      logic                            rdS1;
      logic                            rdS2;
      logic                            rdS3;
      logic                            wrS1;
      logic                            wrS2;
      logic [2*DATA_W-1:0]             q;
      logic [1:0]                      oe;
      logic [LOCK_W-1:0]               lockCnt;
      logic [b4ds_pkg::HEART_W-1:0]    beat;
      logic                            caught;
      logic                            single;
      logic                            bypass;
      logic                            ready;
   } b4ds_link_s;

   typedef struct packed {
      logic       hbPrev;
      logic [3:0] idle;
      logic       dllReset;
      logic       locked;
   } b4ds_sys_s;

   b4ds_link_s lk;
   b4ds_link_s next_lk;
   b4ds_sys_s  sy;
   b4ds_sys_s  next_sy;

   logic linkRst;
   logic dllRstL;
   logic strapL;
   logic clkTrueL;
   logic clkCompL;
   logic readyS;
   logic hbSys;
   logic startRd;
   logic startWr;

   // ----------------------------------------------------------------
   // Crossings
   // ----------------------------------------------------------------

   // Reset, loop reset and pin straps enter the link domain as levels.
   b4ds_sync_if #(.W(5)) toLink (.clk(linkClk));
   b4ds_sync_if #(.W(2)) toSys  (.clk(clk_sys));

   assign toLink.async = {outClkComp, outClkTrue, loop_disable_strap,
                          sy.dllReset, reset};
   assign {clkCompL, clkTrueL, strapL, dllRstL, linkRst} = toLink.synced;

   // The heartbeat bit changes only every few link cycles, so clk_sys sees it.
   assign toSys.async = {lk.ready, lk.beat[b4ds_pkg::HEART_W-1]};
   assign {readyS, hbSys} = toSys.synced;

   b4ds_sync #(.W(5)) linkSync (.port(toLink));
   b4ds_sync #(.W(2)) sysSync  (.port(toSys));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Burst word address, wrapping inside the address space.
   function automatic logic [ADDR_W-1:0] burstAt(input logic [ADDR_W-1:0] base,
                                                 input int unsigned       ofs);
      burstAt = ADDR_W'(base + ADDR_W'(ofs));
   endfunction : burstAt

   // Merge one beat into a stored word lane by lane; selects are active low.
   function automatic logic [DATA_W-1:0] laneMerge(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] data,
                                                   input logic [1:0]        selN);
      laneMerge = old;
      if (!selN[0])
      begin
         laneMerge[LANE-1:0] = data[LANE-1:0];
      end
      if (!selN[1])
      begin
         laneMerge[DATA_W-1:LANE] = data[DATA_W-1:LANE];
      end
   endfunction : laneMerge

   // ----------------------------------------------------------------
   // Port arbitration
   // ----------------------------------------------------------------

   assign startRd = !read_port_select_n && !lk.rdS1;
   // write after write ignored
   // Both selects low give the read the edge unless a read just started.
   assign startWr = !write_port_select_n && !lk.wrS1 && !startRd;

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------

   // Next link state; a stopped link clock simply freezes all of it.
   always_comb
   begin
      logic [ADDR_W-1:0] wIdx;
      int unsigned       wBase;
      wIdx    = '0;
      wBase   = 0;
      next_lk = lk;
      next_lk.rdS1 = startRd;
      next_lk.rdS2 = lk.rdS1;
      next_lk.rdS3 = lk.rdS2;
      next_lk.wrS1 = startWr;
      next_lk.wrS2 = lk.wrS1;
      if (startRd)
      begin
         next_lk.rdAddr = addr;
      end
      if (startWr)
      begin
         next_lk.wrAddr = addr;
      end
      if (lk.rdS2)
      begin
         next_lk.rdTail = burstAt(lk.rdAddr, b4ds_pkg::OFS_LAST);
      end

      if (lk.wrS1 || lk.wrS2)
      begin
         wBase = lk.wrS2 ? b4ds_pkg::OFS_THIRD : 0;
         wIdx  = burstAt(lk.wrAddr, wBase);
         next_lk.mem[wIdx] = laneMerge(lk.mem[wIdx], writeBeats[DATA_W-1:0],
                                       lane_write_select_n[b4ds_pkg::SEL_TRUE +: 2]);
         wIdx  = burstAt(lk.wrAddr, wBase + b4ds_pkg::OFS_SECOND);
         next_lk.mem[wIdx] = laneMerge(lk.mem[wIdx], writeBeats[2*DATA_W-1:DATA_W],
                                       lane_write_select_n[b4ds_pkg::SEL_COMP +: 2]);
      end

      next_lk.oe = b4ds_pkg::OE_RESET;
      if (lk.rdS2)
      begin
         next_lk.q[DATA_W-1:0] = lk.mem[burstAt(lk.rdAddr, b4ds_pkg::OFS_SECOND)];
         next_lk.oe[0] = 1'b1;
      end
      else if (lk.rdS3)
      begin
         next_lk.q[DATA_W-1:0] = lk.mem[lk.rdTail];
         next_lk.oe[0] = 1'b1;
      end
      if (lk.rdS1)
      begin
         next_lk.q[2*DATA_W-1:DATA_W] = lk.mem[lk.rdAddr];
         next_lk.oe[1] = 1'b1;
      end
      else if (lk.rdS2)
      begin
         next_lk.q[2*DATA_W-1:DATA_W] = lk.mem[burstAt(lk.rdAddr, b4ds_pkg::OFS_THIRD)];
         next_lk.oe[1] = 1'b1;
      end

      // count stable cycles to lock
      // No explicit reset is needed for a new rate: the count restarts on a pause.
      next_lk.beat = lk.beat + 1'b1;
      if (dllRstL)
      begin
         next_lk.lockCnt = '0;
      end
      else if (lk.lockCnt != LOCK_END)
      begin
         next_lk.lockCnt = lk.lockCnt + 1'b1;
      end
      next_lk.bypass = !strapL;
      next_lk.ready  = !strapL || (lk.lockCnt == LOCK_END);

      if (!lk.caught)
      begin
         next_lk.caught = 1'b1;
         next_lk.single = clkTrueL && clkCompL;
      end

      if (linkRst)
      begin
         next_lk = '0;
      end
   end

   always_ff @(posedge linkClk)
   begin
      lk <= next_lk;
   end

   // ----------------------------------------------------------------
   // System domain
   // ----------------------------------------------------------------

   // pause resets the loop
   // A missing heartbeat for IDLE_LIMIT cycles marks the link clock stopped.
   always_comb
   begin
      next_sy        = sy;
      next_sy.hbPrev = hbSys;
      if (hbSys != sy.hbPrev)
      begin
         next_sy.idle = '0;
      end
      else if (sy.idle != b4ds_pkg::IDLE_LIMIT)
      begin
         next_sy.idle = sy.idle + 1'b1;
      end
      next_sy.dllReset = (next_sy.idle == b4ds_pkg::IDLE_LIMIT);
      next_sy.locked   = readyS && !sy.dllReset;
      if (reset)
      begin
         next_sy = '0;
         next_sy.dllReset = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      sy <= next_sy;
   end

   // Outputs come straight from the state flops.
   assign readBeats       = lk.q;
   assign readBeatOe      = lk.oe;
   assign singleClockMode = lk.single;
   assign dllBypass       = lk.bypass;
   assign dllLocked       = sy.locked;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   read_pipe_a: assert property (@(posedge linkClk) disable iff (linkRst)
      startRd |-> ##2 readBeatOe[1] ##1 (readBeatOe == 2'b11) ##1 readBeatOe[0])
      else $error("read beats not launched in t+1 to t+3");

   read_skip_a: assert property (@(posedge linkClk) disable iff (linkRst)
      lk.rdS1 |=> !lk.rdS1)
      else $error("read started on two consecutive rises");

   write_skip_a: assert property (@(posedge linkClk) disable iff (linkRst)
      lk.wrS1 |=> !lk.wrS1)
      else $error("write started on two consecutive rises");

   idle_select_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (read_port_select_n && write_port_select_n && !lk.rdS1 && !lk.rdS2)
      |=> ##1 (readBeatOe[1] == 1'b0))
      else $error("outputs driven after idle selects");

   full_beat_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (lk.wrS1 && lane_write_select_n[1:0] == 2'b00)
      |=> lk.mem[$past(lk.wrAddr)] == $past(writeBeats[DATA_W-1:0]))
      else $error("full beat not written");

   low_lane_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (lk.wrS1 && lane_write_select_n[1:0] == 2'b10)
      |=> lk.mem[$past(lk.wrAddr)][DATA_W-1:LANE]
          == $past(lk.mem[lk.wrAddr][DATA_W-1:LANE]))
      else $error("upper lane altered by lower lane write");

   masked_beat_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (lk.wrS1 && lane_write_select_n[1:0] == 2'b11 && !lk.wrS2)
      |=> lk.mem[$past(lk.wrAddr)] == $past(lk.mem[lk.wrAddr]))
      else $error("masked beat altered the array");

   last_word_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (lk.wrS2 && lane_write_select_n[3:2] == 2'b00)
      |=> lk.mem[burstAt($past(lk.wrAddr), b4ds_pkg::OFS_LAST)]
          == $past(writeBeats[2*DATA_W-1:DATA_W]))
      else $error("fourth beat not at A+3");

   lock_time_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (strapL && !dllRstL && lk.lockCnt == LOCK_END - 1'b1) |=> ##1 lk.ready)
      else $error("loop not locked after the lock count");

   pause_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
      (sy.idle == b4ds_pkg::IDLE_LIMIT - 1'b1 && hbSys == sy.hbPrev)
      |=> sy.dllReset ##1 !sy.locked)
      else $error("stopped link clock did not reset the loop");

   reset_idle_a: assert property (@(posedge linkClk)
      linkRst |=> (readBeatOe == 2'b00) && !lk.rdS1 && !lk.wrS1)
      else $error("outputs not released after reset");

   read_burst_c:  cover property (@(posedge linkClk) disable iff (linkRst)
      startRd ##2 startRd);
   write_burst_c: cover property (@(posedge linkClk) disable iff (linkRst)
      startWr ##2 startWr);
   alternate_c:   cover property (@(posedge linkClk) disable iff (linkRst)
      startRd ##1 startWr ##1 startRd);
   loop_reset_c:  cover property (@(posedge clk_sys) disable iff (reset)
      $rose(sy.dllReset));

endmodule : b4ds_port

// File: b4ds_sync.sv
module b4ds_sync #(
   parameter int unsigned W = 1
) (
   b4ds_sync_if.sink port
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } b4ds_sync_s;

   b4ds_sync_s st;
   b4ds_sync_s next_st;

   // The first stage feeds only the second, so metastability dies here.
   always_comb
   begin
      next_st.meta = port.async;
      next_st.held = st.meta;
   end

   // Data path flops carry no reset; they settle within two edges.
   always_ff @(posedge port.clk)
   begin
      st <= next_st;
   end

   assign port.synced = st.held;
endmodule : b4ds_sync

// File: b4ds_sync_if.sv
// ----------------------------------------------------------------
// Level crossing bundle
// ----------------------------------------------------------------

interface b4ds_sync_if #(
   parameter int unsigned W = 1
) (
   input wire logic clk
);
   logic [W-1:0] async;
   logic [W-1:0] synced;

   modport source (output async, input synced);
   modport sink   (input clk, input async, output synced);
endinterface : b4ds_sync_if

// File: tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned LOCK = 16;
   localparam logic [7:0] OE_SEQ = 8'h1E;
   logic        clkSys;
   logic        reset;
   logic        strap;
   logic        outClkHi;
   logic        linkClk;
   logic        rdSelN;
   logic        wrSelN;
   logic [3:0]  addr;
   logic [35:0] writeBeats;
   logic [3:0]  laneSelN;
   logic [35:0] readBeats;
   logic [1:0]  readBeatOe;
   logic        singleClockMode;
   logic        dllBypass;
   logic        dllLocked;
   logic [71:0] q;
   logic [7:0]  oe;
   int          nFail;
   int          nChecks;
   int          cycles;

   // ----
   // Design and master
   // ----
   b4ds_port #(.LOCK_CYC(LOCK)) u_dut (
      .clk_sys(clkSys), .reset(reset), .linkClk(linkClk), .loop_disable_strap(strap),
      .outClkTrue(outClkHi), .outClkComp(outClkHi), .read_port_select_n(rdSelN),
      .write_port_select_n(wrSelN), .addr(addr), .writeBeats(writeBeats),
      .lane_write_select_n(laneSelN), .readBeats(readBeats), .readBeatOe(readBeatOe),
      .singleClockMode(singleClockMode), .dllBypass(dllBypass), .dllLocked(dllLocked));
   b4ds_master u_master (
      .linkClk(linkClk), .read_port_select_n(rdSelN), .write_port_select_n(wrSelN),
      .addr(addr), .writeBeats(writeBeats), .lane_write_select_n(laneSelN),
      .readBeats(readBeats), .readBeatOe(readBeatOe));

   // System clock; time zero values for the straps and reset.
   initial
   begin
      clkSys = 1'b0;
      reset = 1'b1;
      strap = 1'b1;
      outClkHi = 1'b0;
      forever
         #20 clkSys = ~clkSys;
   end

   // Watchdog; the whole run needs under two hundred cycles.
   initial
   begin
      cycles = 0;
      forever
      begin
         @(posedge clkSys);
         cycles++;
         if (cycles == 20000)
         begin
            nFail++;
            end_of_test();
         end
      end
   end

   // ----
   // Shared helpers
   // ----
   task automatic check(input logic [71:0] got, input logic [71:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         nFail++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic sys_wait(input int n);
      repeat (n) @(negedge clkSys);
   endtask : sys_wait

   task automatic do_reset(input logic oc);
      @(negedge clkSys);
      reset = 1'b1;
      outClkHi = oc;
      sys_wait(12);
      reset = 1'b0;
      sys_wait(3);
   endtask : do_reset

   task automatic end_of_test();
      if (nFail == 0 && nChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   // ----
   // Scenarios
   // ----
   task automatic test_power_up();
      check({readBeats, readBeatOe}, 72'h0);
      check({singleClockMode, dllBypass, dllLocked}, 72'h0);
      sys_wait(20);
      check({dllLocked, readBeatOe}, {69'h0, 1'b1, 2'b00});
   endtask : test_power_up

   task automatic test_burst();
      u_master.write_burst(4'h4, 72'hA1_2345_6789_ABCD_EF01, 8'h00, 1'b0);
      u_master.read_burst(4'h4, 1'b0, q, oe);
      check(q, 72'hA1_2345_6789_ABCD_EF01);
      check(oe, OE_SEQ);
   endtask : test_burst

   task automatic test_lanes();
      logic [71:0] d1;
      logic [71:0] d2;
      logic [71:0] m;
      d1 = 72'h123456789ABCDEF012;
      d2 = 72'hFEDCBA9876543210ED;
      m = {18'h3FFFF, 18'h0, 9'h1FF, 9'h0, 9'h0, 9'h1FF};
      u_master.write_burst(4'h8, d1, 8'h00, 1'b0);
      u_master.write_burst(4'h8, d2, 8'h36, 1'b0);
      u_master.read_burst(4'h8, 1'b0, q, oe);
      check(q, (d2 & m) | (d1 & ~m));
   endtask : test_lanes

   task automatic test_back_to_back();
      u_master.write_burst(4'h8, 72'h0F_0F0F_0F0F_0F0F_0F0F, 8'h00, 1'b0);
      u_master.write_burst(4'h4, 72'h5A_5A5A_5A5A_5A5A_5A5A, 8'h00, 1'b1);
      u_master.read_burst(4'h8, 1'b0, q, oe);
      check(q, 72'h0F_0F0F_0F0F_0F0F_0F0F);
      u_master.read_burst(4'h4, 1'b1, q, oe);
      check(q, 72'h5A_5A5A_5A5A_5A5A_5A5A);
      check(oe, OE_SEQ);
   endtask : test_back_to_back

   task automatic test_stop();
      logic [35:0] held;
      held = readBeats;
      u_master.clkRun = 1'b0;
      sys_wait(12);
      check({dllLocked, readBeatOe, readBeats}, {36'h0, held});
      u_master.clkRun = 1'b1;
      sys_wait(2);
      check(dllLocked, 72'h0);
      sys_wait(20);
      check(dllLocked, 72'h1);
   endtask : test_stop

   task automatic test_bypass();
      strap = 1'b0;
      sys_wait(10);
      check({dllBypass, dllLocked}, 72'h3);
      strap = 1'b1;
      sys_wait(10);
      check(dllBypass, 72'h0);
   endtask : test_bypass

   task automatic test_single_clock();
      do_reset(1'b1);
      sys_wait(4);
      check(singleClockMode, 72'h1);
      outClkHi = 1'b0;
      sys_wait(10);
      check(singleClockMode, 72'h1);
      u_master.write_burst(4'hC, 72'h3C_3C3C_3C3C_3C3C_3C3C, 8'h00, 1'b0);
      u_master.read_burst(4'hC, 1'b0, q, oe);
      check(q, 72'h3C_3C3C_3C3C_3C3C_3C3C);
      check(oe, OE_SEQ);
   endtask : test_single_clock

   // Main sequence.
   initial
   begin
      nFail = 0;
      nChecks = 0;
      do_reset(1'b0);
      test_power_up();
      test_burst();
      test_lanes();
      test_back_to_back();
      test_stop();
      test_bypass();
      test_single_clock();
      end_of_test();
   end
endmodule : tb_top
